/* design/stop_mode_power_sequencer.v */
// stop mode power sequencer top module
//
// Decided for this implementation: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "stop_seq_map.vh"
module stop_mode_power_sequencer
(
    input  wire                 clk,
    input  wire                 nrst,
    input  wire [`ADDR_W-1:0]   addr,
    input  wire [`DATA_W-1:0]   wdata,
    input  wire                 wr,
    input  wire                 rd,
    output reg  [`DATA_W-1:0]   rdata,
    input  wire                 stop_exec,
    input  wire                 reset_pin_n,
    input  wire                 irq_pin_n,
    input  wire                 keypad_irq,
    input  wire                 tick_event,
    input  wire                 serial_rx_irq,
    input  wire                 adc_irq,
    input  wire                 lowv_interrupt,
    input  wire                 dbg_mem_status_cmd,
    input  wire                 dbg_background_cmd,
    input  wire [`PORT_W-1:0]   port_out,
    input  wire [`PORT_W-1:0]   port_dir,
    input  wire [`PORT_W-1:0]   periph_en,
    input  wire [`PORT_W-1:0]   periph_out,
    input  wire [`PORT_W-1:0]   periph_dir,
    output reg  [`PORT_W-1:0]   pin_out,
    output reg  [`PORT_W-1:0]   pin_oe,
    output reg                  in_stop2,
    output reg                  in_stop3,
    output reg                  periph_clk_en,
    output reg                  dbg_clk_en,
    output reg                  regulator_full,
    output reg                  power_off_logic,
    output reg                  osc_run,
    output reg                  adc_run,
    output reg                  tick_source_en,
    output reg                  por_reset,
    output reg                  illegal_reset,
    output reg                  pin_reset,
    output reg                  wake_irq,
    output reg                  enter_background,
    output reg                  dbg_stop_error
);
    localparam ST_RUN   = 3'b001;
    localparam ST_STOP2 = 3'b010;
    localparam ST_STOP3 = 3'b100;

    reg [2:0] state;
    reg [2:0] next_state;
    reg       partial_power_down_select;
    reg       power_down_wake_flag;
    reg       pins_latched;
    reg [2:0] rti_period_select;
    reg       stop_allow;
    reg       debug_mode_allow;
    reg       lowv_detect_on;
    reg       lowv_detect_in_stop;
    reg       osc_run_in_stop;
    reg       adc_async_clk;
    reg [`PORT_W-1:0] held_out;
    reg [`PORT_W-1:0] held_dir;

    // three-stage synchronisers for pins
    reg [2:0] rst_s;
    reg [2:0] irq_s;
    reg [2:0] kbi_s;
    reg       rst_n_q;
    reg       irq_n_q;
    reg       kbi_q;
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_s <= 3'h7;
            irq_s <= 3'h7;
            kbi_s <= 3'h0;
            rst_n_q <= 1'b1;
            irq_n_q <= 1'b1;
            kbi_q <= 1'b0;
        end
        else
        begin
            rst_s <= {rst_s[1:0], reset_pin_n};
            irq_s <= {irq_s[1:0], irq_pin_n};
            kbi_s <= {kbi_s[1:0], keypad_irq};
            if (rst_s[1] == rst_s[2])
                rst_n_q <= rst_s[2];
            if (irq_s[1] == irq_s[2])
                irq_n_q <= irq_s[2];
            if (kbi_s[1] == kbi_s[2])
                kbi_q <= kbi_s[2];
        end
    end

    wire lowv_armed = lowv_detect_on & lowv_detect_in_stop;
    wire tick_on    = (rti_period_select != `TICK_OFF);
    wire tick_wake  = tick_on & tick_event;
    wire ack_wr     = wr & (addr == `REG_CTRL) & wdata[`CTRL_ACK_BIT];
    // irq treated active low in stop2
    wire wake2 = ~rst_n_q | ~irq_n_q | tick_wake;
    wire wake3_int = ~irq_n_q | kbi_q | tick_wake | serial_rx_irq
                   | adc_irq | lowv_interrupt
                   | (debug_mode_allow & dbg_background_cmd);
    wire go_stop2 = stop_allow & partial_power_down_select
                  & ~lowv_armed & ~debug_mode_allow;
    wire wake3_int_other = ~irq_n_q | kbi_q | tick_wake | serial_rx_irq
                         | adc_irq | lowv_interrupt;

    // true on the edge that moves from one mode to another
    function leaves;
        input [2:0] cur;
        input [2:0] nxt;
        input [2:0] from;
        input [2:0] to;
        begin
            leaves = (cur == from) && (nxt == to);
        end
    endfunction

    wire exit2  = leaves(state, next_state, ST_STOP2, ST_RUN);
    wire exit3  = leaves(state, next_state, ST_STOP3, ST_RUN);
    wire enter2 = leaves(state, next_state, ST_RUN, ST_STOP2);
    wire cfg_wr = wr & (state == ST_RUN);

    always @*
    begin
        next_state = state;
        case (state)
            ST_RUN:
                if (stop_exec & stop_allow)
                    next_state = go_stop2 ? ST_STOP2 : ST_STOP3;
            ST_STOP2:
                if (wake2)
                    next_state = ST_RUN;
            ST_STOP3:
                if (~rst_n_q | wake3_int)
                    next_state = ST_RUN;
            default:
                next_state = ST_RUN;
        endcase
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            state <= ST_RUN;
            power_down_wake_flag <= 1'b0;
            pins_latched <= 1'b0;
            held_out <= {`PORT_W{1'b0}};
            held_dir <= {`PORT_W{1'b0}};
            por_reset <= 1'b0;
            illegal_reset <= 1'b0;
            pin_reset <= 1'b0;
            wake_irq <= 1'b0;
            enter_background <= 1'b0;
            dbg_stop_error <= 1'b0;
        end
        else
        begin
            state <= next_state;
            por_reset <= 1'b0;
            illegal_reset <= 1'b0;
            pin_reset <= 1'b0;
            wake_irq <= 1'b0;
            enter_background <= 1'b0;
            dbg_stop_error <= (state != ST_RUN) & dbg_mem_status_cmd;
            if (state == ST_RUN && stop_exec && !stop_allow)
                illegal_reset <= 1'b1;
            if (enter2)
            begin
                pins_latched <= 1'b1;
                held_out <= pin_out;
                held_dir <= pin_oe;
            end
            if (exit2)
                por_reset <= 1'b1;
            if (exit3)
            begin
                pin_reset <= ~rst_n_q;
                wake_irq <= rst_n_q;
                enter_background <= rst_n_q & ~wake3_int_other
                                  & debug_mode_allow;
            end
            // stop2 wake sets the flag, set wins over ack
            if (exit2)
                power_down_wake_flag <= 1'b1;
            else if (ack_wr)
                power_down_wake_flag <= 1'b0;
            if (ack_wr && state == ST_RUN)
                pins_latched <= 1'b0;
        end
    end

    // configuration bits, back to defaults on a stop2 wake
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            partial_power_down_select <= 1'b0;
            rti_period_select <= `TICK_OFF;
            stop_allow <= 1'b0;
            debug_mode_allow <= 1'b0;
            lowv_detect_on <= 1'b0;
            lowv_detect_in_stop <= 1'b0;
            osc_run_in_stop <= 1'b0;
            adc_async_clk <= 1'b0;
        end
        else if (exit2)
        begin
            // restart as power-on, config registers to default
            partial_power_down_select <= 1'b0;
            rti_period_select <= `TICK_OFF;
            stop_allow <= 1'b0;
            debug_mode_allow <= 1'b0;
            lowv_detect_on <= 1'b0;
            lowv_detect_in_stop <= 1'b0;
            osc_run_in_stop <= 1'b0;
            adc_async_clk <= 1'b0;
        end
        else if (cfg_wr)
        begin
            case (addr)
                `REG_CTRL:
                    partial_power_down_select <= wdata[`CTRL_SEL_BIT];
                `REG_TICK:
                    rti_period_select <= wdata[`TICK_MSB:0];
                `REG_OPT:
                begin
                    stop_allow <= wdata[`OPT_STOP_ALLOW_BIT];
                    debug_mode_allow <= wdata[`OPT_DBG_BIT];
                    lowv_detect_on <= wdata[`OPT_LOWV_DETECT_ON_BIT];
                    lowv_detect_in_stop <= wdata[`OPT_LOWV_DETECT_IN_STOP_BIT];
                    osc_run_in_stop <= wdata[`OPT_OSC_BIT];
                    adc_async_clk <= wdata[`OPT_ADCK_BIT];
                end
                default:
                    ;
            endcase
        end
    end

    // read mux, data stand only in the cycle after the strobe
    reg [`DATA_W-1:0] next_rdata;
    always @*
    begin
        next_rdata = {`DATA_W{1'b0}};
        if (rd)
        begin
            case (addr)
                `REG_CTRL:
                begin
                    next_rdata[`CTRL_SEL_BIT] = partial_power_down_select;
                end
                `REG_STATUS:
                begin
                    next_rdata[`STAT_FLAG_BIT] = power_down_wake_flag;
                    next_rdata[`STAT_LATCH_BIT] = pins_latched;
                    next_rdata[`STAT_S2_BIT] = (state == ST_STOP2);
                    next_rdata[`STAT_S3_BIT] = (state == ST_STOP3);
                end
                `REG_TICK:
                begin
                    next_rdata[`TICK_MSB:0] = rti_period_select;
                end
                `REG_OPT:
                begin
                    next_rdata[`OPT_STOP_ALLOW_BIT] = stop_allow;
                    next_rdata[`OPT_DBG_BIT] = debug_mode_allow;
                    next_rdata[`OPT_LOWV_DETECT_ON_BIT] = lowv_detect_on;
                    next_rdata[`OPT_LOWV_DETECT_IN_STOP_BIT] = lowv_detect_in_stop;
                    next_rdata[`OPT_OSC_BIT] = osc_run_in_stop;
                    next_rdata[`OPT_ADCK_BIT] = adc_async_clk;
                end
                default:
                begin
                    next_rdata = {`DATA_W{1'b0}};
                end
            endcase
        end
    end

    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rdata <= {`DATA_W{1'b0}};
        end
        else
        begin
            rdata <= next_rdata;
        end
    end

    // pin drive and power outputs
    genvar g;
    generate
        for (g = 0; g < `PORT_W; g = g + 1)
        begin : pin_mux
            always @(posedge clk or negedge nrst)
            begin
                if (!nrst)
                begin
                    pin_out[g] <= 1'b0;
                    pin_oe[g] <= 1'b0;
                end
                else if (enter2)
                begin
                    pin_out[g] <= pin_out[g];
                    pin_oe[g] <= pin_oe[g];
                end
                else if (pins_latched)
                begin
                    pin_out[g] <= held_out[g];
                    pin_oe[g] <= held_dir[g];
                end
                else if (periph_en[g])
                begin
                    pin_out[g] <= periph_out[g];
                    pin_oe[g] <= periph_dir[g];
                end
                else
                begin
                    pin_out[g] <= port_out[g];
                    pin_oe[g] <= port_dir[g];
                end
            end
        end
    endgenerate

    wire stop_any = (next_state != ST_RUN);
    always @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            in_stop2 <= 1'b0;
            in_stop3 <= 1'b0;
            periph_clk_en <= 1'b1;
            dbg_clk_en <= 1'b1;
            regulator_full <= 1'b1;
            power_off_logic <= 1'b0;
            osc_run <= 1'b1;
            adc_run <= 1'b1;
            tick_source_en <= 1'b0;
        end
        else
        begin
            in_stop2 <= (next_state == ST_STOP2);
            in_stop3 <= (next_state == ST_STOP3);
            periph_clk_en <= ~stop_any;
            dbg_clk_en <= ~stop_any | debug_mode_allow;
            regulator_full <= ~stop_any | debug_mode_allow
                            | lowv_armed;
            power_off_logic <= (next_state == ST_STOP2);
            osc_run <= ~stop_any
                     | ((next_state == ST_STOP3) & osc_run_in_stop);
            adc_run <= ~stop_any | ((next_state == ST_STOP3)
                     & adc_async_clk & lowv_detect_on);
            tick_source_en <= tick_on;
        end
    end
endmodule // stop_mode_power_sequencer
`default_nettype wire

/* design/stop_seq_map.vh */
// constants for the stop mode power sequencer
`ifndef STOP_SEQ_MAP_VH
`define STOP_SEQ_MAP_VH
`define ADDR_W            4
`define DATA_W            8
`define REG_CTRL          4'h0
`define REG_STATUS        4'h1
`define REG_TICK          4'h2
`define REG_OPT           4'h3
`define CTRL_ACK_BIT      0
`define CTRL_SEL_BIT      1
`define OPT_STOP_ALLOW_BIT     0
`define OPT_DBG_BIT       1
`define OPT_LOWV_DETECT_ON_BIT      2
`define OPT_LOWV_DETECT_IN_STOP_BIT     3
`define OPT_OSC_BIT       4
`define OPT_ADCK_BIT      5
`define TICK_OFF          3'h0
`define TICK_MSB          2
`define STAT_FLAG_BIT     0
`define STAT_LATCH_BIT    1
`define STAT_S2_BIT       2
`define STAT_S3_BIT       3
`define PORT_W            8
`endif

/* tb/stop_seq_chk_assertions.sv */
// port-level checker for the stop mode power sequencer
`timescale 1ns/1ps
`default_nettype none
module stop_seq_chk
(
    input wire logic       clk, nrst, stop_exec, irq_pin_n, reset_pin_n,
    input wire logic       tick_event, dbg_mem_status_cmd, in_stop2,
    input wire logic       in_stop3, periph_clk_en, dbg_clk_en,
    input wire logic       regulator_full, power_off_logic, por_reset,
    input wire logic       illegal_reset, pin_reset, wake_irq,
    input wire logic       dbg_stop_error,
    input wire logic [7:0] pin_out, pin_oe
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    wire stp = in_stop2 | in_stop3;
    property p_one_mode; !(in_stop2 && in_stop3); endproperty
    property p_gate; stp |-> !periph_clk_en; endproperty
    property p_s2_pwr;
        in_stop2 |-> power_off_logic && !regulator_full && !dbg_clk_en;
    endproperty
    property p_held;
        in_stop2 && $past(in_stop2) |-> $stable(pin_out) && $stable(pin_oe);
    endproperty
    property p_irq; (in_stop2 && !irq_pin_n)[*3] |-> ##[0:6] !in_stop2;
    endproperty
    property p_quiet;
        (in_stop2 && reset_pin_n && irq_pin_n && !tick_event)[*8] |=> in_stop2;
    endproperty
    property p_por; $fell(in_stop2) |-> ##[0:1] por_reset; endproperty
    property p_s3_exit; $fell(in_stop3) |-> ##[0:1] (pin_reset || wake_irq);
    endproperty
    property p_illegal;
        illegal_reset |-> !stp && ($past(stop_exec) || $past(stop_exec, 2));
    endproperty
    property p_dbg_err; dbg_mem_status_cmd && stp |-> ##[1:2] dbg_stop_error;
    endproperty
    a_one_mode: assert property (p_one_mode) else $error("two modes");
    a_gate: assert property (p_gate) else $error("clock on");
    a_s2_pwr: assert property (p_s2_pwr) else $error("stop2 power");
    a_held: assert property (p_held) else $error("pins moved");
    a_irq: assert property (p_irq) else $error("no irq wake");
    a_quiet: assert property (p_quiet) else $error("bad exit");
    a_por: assert property (p_por) else $error("no por");
    a_s3_exit: assert property (p_s3_exit) else $error("no exit");
    a_illegal: assert property (p_illegal) else $error("bad illegal");
    a_dbg_err: assert property (p_dbg_err) else $error("no error");
    c_s2_exit: cover property (in_stop2 ##1 !in_stop2);
    c_dbg_s3: cover property (in_stop3 && dbg_clk_en);
    c_illegal: cover property (illegal_reset);
endmodule // stop_seq_chk
bind stop_mode_power_sequencer stop_seq_chk u_chk
(
    .clk, .nrst, .stop_exec, .irq_pin_n, .reset_pin_n, .tick_event,
    .dbg_mem_status_cmd, .in_stop2, .in_stop3, .periph_clk_en, .dbg_clk_en,
    .regulator_full, .power_off_logic, .por_reset, .illegal_reset,
    .pin_reset, .wake_irq, .dbg_stop_error, .pin_out, .pin_oe
);
`default_nettype wire

/* tb/wake_source_model.sv */
// wake pins and wake requests of the far side
`timescale 1ns/1ps
`default_nettype none
module wake_source_model #(parameter int HOLD = 8)
(
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [2:0] src,
    output logic            reset_pin_n, irq_pin_n, keypad_irq, tick_event,
    output logic            serial_rx_irq, adc_irq, lowv_interrupt
);
    int left = 0;
    logic [2:0] sel = 3'h0;
    always @(posedge clk)
    begin
        if (go)
        begin
            left <= HOLD;
            sel <= src;
        end
        else if (left > 0)
            left <= left - 1;
    end
    wire act = (left > 0);
    // pulled-up pins go back high once released
    assign reset_pin_n = !(act && sel == 3'h0);
    assign irq_pin_n = !(act && sel == 3'h1);
    assign keypad_irq = act && sel == 3'h2;
    assign tick_event = act && sel == 3'h3;
    assign serial_rx_irq = act && sel == 3'h4;
    assign adc_irq = act && sel == 3'h5;
    assign lowv_interrupt = act && sel == 3'h6;
endmodule // wake_source_model
`default_nettype wire

/* tb/stop_mode_power_sequencer_test.sv */
// self-checking bench for the stop mode power sequencer
`timescale 1ns/1ps
`default_nettype none
`include "stop_seq_map.vh"
module stop_mode_power_sequencer_test;
    logic clk, nrst, wr, rd, stop_exec, go, dbg_mem_status_cmd;
    logic dbg_background_cmd, reset_pin_n, irq_pin_n, keypad_irq, tick_event;
    logic serial_rx_irq, adc_irq, lowv_interrupt, in_stop2, in_stop3;
    logic periph_clk_en, dbg_clk_en, regulator_full, power_off_logic, osc_run;
    logic adc_run, tick_source_en, por_reset, illegal_reset, pin_reset;
    logic wake_irq, enter_background, dbg_stop_error;
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata, rdata;
    logic [2:0]         src;
    logic [`PORT_W-1:0] port_out, port_dir, periph_en, periph_out, periph_dir;
    logic [`PORT_W-1:0] pin_out, pin_oe;
    logic [7:0]         cnt [6] = '{default: 8'h00};
    logic [7:0]         b;
    int                 errors = 0, comparisons = 0;
    stop_mode_power_sequencer u_dut
    (
        .clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .stop_exec,
        .reset_pin_n, .irq_pin_n, .keypad_irq, .tick_event, .serial_rx_irq,
        .adc_irq, .lowv_interrupt, .dbg_mem_status_cmd, .dbg_background_cmd,
        .port_out, .port_dir, .periph_en, .periph_out, .periph_dir, .pin_out,
        .pin_oe, .in_stop2, .in_stop3, .periph_clk_en, .dbg_clk_en,
        .regulator_full, .power_off_logic, .osc_run, .adc_run,
        .tick_source_en, .por_reset, .illegal_reset, .pin_reset, .wake_irq,
        .enter_background, .dbg_stop_error
    );
    wake_source_model #(.HOLD(8)) u_src
    (
        .clk, .go, .src, .reset_pin_n, .irq_pin_n, .keypad_irq, .tick_event,
        .serial_rx_irq, .adc_irq, .lowv_interrupt
    );
    wire [5:0] pls = {dbg_stop_error, enter_background, wake_irq, pin_reset,
                      illegal_reset, por_reset};
    always @(posedge clk)
        for (int i = 0; i < 6; i++)
            if (pls[i] === 1'b1)
                cnt[i] <= cnt[i] + 8'h01;
    task chk(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h",
                     $time, seen, exp);
        end
    endtask
    task wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 chk(rdata, exp);
    endtask
    task stop(input logic [7:0] opt, input logic [7:0] ctl);
        wr_reg(`REG_OPT, opt);
        wr_reg(`REG_CTRL, ctl);
        @(posedge clk);
        stop_exec <= 1'b1;
        @(posedge clk);
        stop_exec <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
    endtask
    task wake(input logic [2:0] s, input int k);
        b = cnt[k];
        @(posedge clk);
        src <= s;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 40 && (in_stop2 || in_stop3); i++)
            @(posedge clk);
        repeat (10) @(posedge clk);
        #1 chk(cnt[k] - b, 8'h01);
        chk({in_stop2, in_stop3}, 8'h00);
    endtask
    task finish_test;
        $display("comparisons %0d errors %0d", comparisons, errors);
        if (errors == 0 && comparisons > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial
    begin
        repeat (6000) @(posedge clk);
        errors++;
        finish_test;
    end
    initial
    begin
        {nrst, wr, rd, stop_exec, go, dbg_mem_status_cmd} = '0;
        {dbg_background_cmd, addr, wdata, src, port_out, port_dir} = '0;
        {periph_en, periph_out, periph_dir} = '0;
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        rd_chk(`REG_STATUS, 8'h00);
        wr_reg(`REG_CTRL, 8'h03);
        rd_chk(`REG_CTRL, 8'h02);
        rd_chk(4'hF, 8'h00);
        stop(8'h00, 8'h02);
        chk(cnt[1], 8'h01);
        chk({in_stop2, in_stop3}, 8'h00);
        $display("test illegal stop done");
        @(posedge clk);
        {port_out, port_dir, periph_out} <= {8'hA5, 8'hF0, 8'hFF};
        stop(8'h01, 8'h02);
        chk(in_stop2, 1'b1);
        chk(pin_out, 8'hA5);
        @(posedge clk);
        port_out <= 8'h3C;
        wake(3'h1, 0);
        chk(pin_out, 8'hA5);
        rd_chk(`REG_OPT, 8'h00);
        wr_reg(`REG_CTRL, 8'h00);
        rd_chk(`REG_STATUS, 8'h03);
        wr_reg(`REG_CTRL, 8'h01);
        rd_chk(`REG_STATUS, 8'h00);
        repeat (3) @(posedge clk);
        #1 chk(pin_out, 8'h3C);
        chk(pin_oe, 8'hF0);
        $display("test stop2 done");
        stop(8'h0D, 8'h02);
        chk(in_stop3, 1'b1);
        chk(regulator_full, 1'b1);
        wake(3'h2, 3);
        rd_chk(`REG_OPT, 8'h0D);
        stop(8'h03, 8'h02);
        chk({in_stop3, dbg_clk_en, regulator_full}, 8'h07);
        chk(periph_clk_en, 1'b0);
        @(posedge clk);
        dbg_mem_status_cmd <= 1'b1;
        @(posedge clk);
        dbg_mem_status_cmd <= 1'b0;
        repeat (3) @(posedge clk);
        #1 chk(cnt[5], 8'h01);
        chk(in_stop3, 1'b1);
        @(posedge clk);
        dbg_background_cmd <= 1'b1;
        @(posedge clk);
        dbg_background_cmd <= 1'b0;
        repeat (12) @(posedge clk);
        #1 chk(cnt[4], 8'h01);
        chk(in_stop3, 8'h00);
        $display("test debug stop done");
        stop(8'h31, 8'h00);
        chk({in_stop3, osc_run, adc_run, regulator_full},
            8'h0C);
        wake(3'h0, 2);
        wr_reg(`REG_TICK, 8'h00);
        stop(8'h01, 8'h00);
        @(posedge clk);
        src <= 3'h3;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        repeat (12) @(posedge clk);
        #1 chk({in_stop3, tick_source_en}, 8'h02);
        wake(3'h1, 3);
        wr_reg(`REG_TICK, 8'h03);
        for (int s = 3; s < 7; s++)
        begin
            stop(8'h01, 8'h00);
            chk(tick_source_en, 1'b1);
            wake(s[2:0], 3);
        end
        $display("test stop3 wake sources done");
        finish_test;
    end
endmodule // stop_mode_power_sequencer_test
`default_nettype wire
